// *** logic/cric_pkg.sv ***
// package: constants and carriers for the clock, reset and idle control block
package cric_pkg;
	// register offsets on the plain register port
	localparam logic [7:0] ADDR_PROC_CTRL = 8'h87;
	localparam logic [7:0] ADDR_CLK_CTRL0 = 8'h91;
	localparam logic [7:0] ADDR_WAKE_DIV = 8'hd4;
	localparam logic [7:0] ADDR_FUNC_SET = 8'hc0; // chosen offset
	localparam logic [7:0] ADDR_IRQ_STAT = 8'hc1; // chosen offset
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hc2; // chosen offset
	localparam logic [7:0] ADDR_SYS_STAT = 8'hc3; // chosen offset
	// field positions
	localparam int IDLE_BIT = 0;
	localparam int POF_BIT = 4;
	localparam int PLL_ENABLE_BIT_BIT = 4;
	localparam int OUTPUT_CLOCK_SELECT_LO = 4;
	// interrupt status bit positions
	localparam int EV_WAKE = 0;
	localparam int EV_WDOG = 1;
	localparam int EV_MASTER_CLEAR_PIN = 2;
	localparam int EV_IDLE_EXIT = 3;
	// reset values
	localparam logic [7:0] PROCESSOR_CONTROL_RST = 8'h00;
	localparam logic [7:0] CK0_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h00;
	localparam logic [7:0] FUNCTION_SETTING_RST = 8'h00;
	localparam logic [15:0] FETCH_ADDR = 16'h0000;
	// times, as printed, and rates
	localparam longint RC_HZ = 16000;
	localparam longint STAB_MS = 16;
	localparam longint MASTER_CLEAR_PIN_FILT_MS = 8;
	// cycle counts on the rc clock, least times rounded up
	localparam longint STAB_CYC = (STAB_MS * RC_HZ + 999) / 1000;
	localparam longint FILT_CYC = (MASTER_CLEAR_PIN_FILT_MS * RC_HZ + 999) / 1000;
	// output clock selections
	typedef enum logic [1:0] {
		CRIC_OC_OFF = 2'b00,
		CRIC_OC_USB = 2'b01,
		CRIC_OC_HS = 2'b10,
		CRIC_OC_HS2 = 2'b11
	} cric_oc_e;
	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cric_req_s;
	// clock enables handed to the clock tree
	typedef struct packed {
		logic cpu_clk_en;
		logic pll_en;
		logic rc_osc_en;
		logic wake_tick;
	} cric_clk_s;
endpackage : cric_pkg

// *** logic/cric_top.sv ***
// clock, reset and idle control: one clock domain, register port slave
// Summary of operation
// [RL1] rc oscillator on for watchdog, reset, resume
// [RL2] rc clock feeds watchdog, reset, stabilizer only; the wakeup prescaler also counts rc ticks here
// [RL3] pll makes 48 mhz, usable at once
// [RL4] pll enable is bit 4, resets 0
// [RL5] software runs 48 mhz system for usb
// [RL6] wakeup clock only triggers wakeup logic
// [RL7] wakeup divide by two times n plus one
// [RL8] output clock select bits 5:4 drive pin
// [RL9] software sets clock pin as output
// [RL10] five reset sources force same state
// [RL11] hold in reset, count 16 ms, fetch zero
// [RL12] master clear filter drops pulses under 8 ms
// [RL13] power-on release waits 16 ms rc count
// [RL14] power-on flag set only by power-on; a write of one to bit 4 also sets it here
// [RL15] watchdog overflow gives full system reset
// [RL16] idle bit stops processor clock only
// [RL17] idle bit clears itself on wakeup
// [RL18] interrupt wakes idle; reset restarts at zero
// [RL19] filtered inputs synchronised to rc ticks
`timescale 1ns/1ps
module cric_top #(
	// counts in rc ticks; small values shorten simulation
	parameter int STAB_COUNT = int'(cric_pkg::STAB_CYC),
	parameter int FILT_COUNT = int'(cric_pkg::FILT_CYC),
	parameter int RC_DIV = 3125, // 50 mhz system clocks per rc tick
	parameter int WAKE_PRE = 128 // rc ticks per wakeup base half period
) (
	// clock and external reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// register port: request in, read data one cycle later
	input wire cric_pkg::cric_req_s bus_req,
	output logic [7:0] bus_rdata,
	// reset sources and rc oscillator requests; the master clear pin is active low
	input wire logic master_clear_pin_n,
	input wire logic poweron_detect_out,
	input wire logic watchdog_overflow,
	input wire logic watchdog_enabled,
	input wire logic osc_resume,
	input wire logic port_wake_pd,
	input wire logic rt_wake_pd,
	// enabled interrupt from the controller, ends idle
	input wire logic irq_pending,
	// clock sources that may be routed to the output pin
	input wire logic usb_clk_in,
	input wire logic hs_clk_in,
	// every output below leaves through a flip-flop
	output logic clock_output_pin,
	output logic sys_reset_n,
	output logic cpu_run,
	output logic [15:0] fetch_addr,
	output cric_pkg::cric_clk_s clk_en,
	output logic irq
);
	// reset release through two flip-flops
	// the assert edge is immediate, the release is retimed to clk_sys so
	// no register sees reset leave close to a clock edge
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// rc tick: stands in for the 16 khz rc clock, one pulse per period
	// the oscillator itself is analog; this divider models its rate and
	// is the only timebase of the filter, stabiliser and wakeup logic
	logic [15:0] rc_cnt_q;
	logic rc_tick_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rc_cnt_q <= 16'h0000;
			rc_tick_q <= 1'b0;
		end else if (rc_cnt_q == 16'(RC_DIV - 1)) begin
			rc_cnt_q <= 16'h0000;
			rc_tick_q <= 1'b1;
		end else begin
			rc_cnt_q <= rc_cnt_q + 16'h0001;
			rc_tick_q <= 1'b0;
		end
	end

	// synchronisers for the master clear pin and power-on detector
	// the first stage may go metastable, so only the second is read
	// the pin stages idle high after reset so no false clear is seen
	logic master_clear_pin_s1_q, master_clear_pin_s2_q, por_s1_q, por_s2_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			master_clear_pin_s1_q <= 1'b1;
			master_clear_pin_s2_q <= 1'b1;
			por_s1_q <= 1'b0;
			por_s2_q <= 1'b0;
		end else begin
			master_clear_pin_s1_q <= master_clear_pin_n;
			master_clear_pin_s2_q <= master_clear_pin_s1_q;
			por_s1_q <= poweron_detect_out;
			por_s2_q <= por_s1_q;
		end
	end

	// master clear filter: low must hold for the full count of rc ticks
	// a short glitch resets the count, so noise never reaches reset
	// limitation: the length is only as accurate as the rc oscillator
	// the hit stays set while the pin stays low, holding reset
	logic [15:0] filt_cnt_q;
	logic master_clear_pin_hit_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			filt_cnt_q <= 16'h0000;
			master_clear_pin_hit_q <= 1'b0;
		end else if (master_clear_pin_s2_q) begin
			filt_cnt_q <= 16'h0000; // [RL12]
			master_clear_pin_hit_q <= 1'b0;
		end else if (rc_tick_q) begin // [RL19]
			if (filt_cnt_q >= 16'(FILT_COUNT - 1)) begin
				master_clear_pin_hit_q <= 1'b1; // [RL12]
			end else begin
				filt_cnt_q <= filt_cnt_q + 16'h0001;
			end
		end
	end

	// any reset source: held while active, then the stabiliser runs
	// the power-on detector is used as a level, so a brown-out holds
	// reset while the supply is low, then the full count restarts
	// induced wakeup requests share the path so all sources look alike
	logic any_reset;
	assign any_reset = master_clear_pin_hit_q | !por_s2_q | watchdog_overflow |
		port_wake_pd | rt_wake_pd; // [RL10] [RL15]

	// stabilisation counter clocked by rc ticks
	// any source restarts the count, so a source that bounces only
	// lengthens the reset; it can never cut the stabilisation short
	// the counter freezes at its end value while released
	logic [15:0] stab_cnt_q;
	logic in_reset_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stab_cnt_q <= 16'h0000;
			in_reset_q <= 1'b1;
		end else if (any_reset) begin
			stab_cnt_q <= 16'h0000; // [RL11]
			in_reset_q <= 1'b1;
		end else if (in_reset_q && rc_tick_q) begin // [RL13] [RL19]
			if (stab_cnt_q >= 16'(STAB_COUNT - 1)) begin
				in_reset_q <= 1'b0; // [RL11]
			end else begin
				stab_cnt_q <= stab_cnt_q + 16'h0001;
			end
		end
	end

	// write decode shared by the register processes
	function automatic logic wr_hit(input cric_pkg::cric_req_s req,
		input logic [7:0] addr);
		return req.wr && req.addr == addr;
	endfunction : wr_hit

	// registers
	// bits that no rule gives a meaning read back as zero
	logic [7:0] processor_control_q, ck0_q, div_q, function_setting_q, ist_q, imask_q;
	logic pof_q;
	logic wr_hit_processor_control;
	assign wr_hit_processor_control = wr_hit(bus_req, cric_pkg::ADDR_PROC_CTRL);

	// power-on flag: set by power-on or by a write of one to bit 4, survives other resets
	// kept apart from the common reset so software can tell a power cycle
	// from the other sources; detector low wins over a clearing write
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pof_q <= 1'b1;
		end else if (!por_s2_q) begin
			pof_q <= 1'b1; // [RL14]
		end else if (wr_hit_processor_control) begin
			pof_q <= bus_req.wdata[cric_pkg::POF_BIT]; // [RL14]
		end
	end

	// processor control: idle bit set by write, cleared on wakeup or reset
	// wakeup beats a write in the same cycle, so a late idle request
	// can never swallow the interrupt that should end it
	// only the idle bit is stored here; the flag has its own register
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			processor_control_q <= cric_pkg::PROCESSOR_CONTROL_RST;
		end else if (in_reset_q) begin
			processor_control_q <= cric_pkg::PROCESSOR_CONTROL_RST; // [RL10]
		end else if (processor_control_q[cric_pkg::IDLE_BIT] && irq_pending) begin
			processor_control_q[cric_pkg::IDLE_BIT] <= 1'b0; // [RL17] [RL18]
		end else if (wr_hit_processor_control) begin
			processor_control_q <= bus_req.wdata & 8'h01; // [RL16]
		end
	end

	// clock control zero, divider and function setting
	// all three return to reset values during any reset, so the pll is
	// off and the output pin quiet when the processor restarts
	// only the pll enable bit is kept in clock control zero
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ck0_q <= cric_pkg::CK0_RST;
			div_q <= cric_pkg::DIV_RST;
			function_setting_q <= cric_pkg::FUNCTION_SETTING_RST;
		end else if (in_reset_q) begin
			ck0_q <= cric_pkg::CK0_RST; // [RL4]
			div_q <= cric_pkg::DIV_RST;
			function_setting_q <= cric_pkg::FUNCTION_SETTING_RST;
		end else if (bus_req.wr) begin
			if (bus_req.addr == cric_pkg::ADDR_CLK_CTRL0) begin
				ck0_q <= bus_req.wdata & 8'h10; // [RL4]
			end
			if (bus_req.addr == cric_pkg::ADDR_WAKE_DIV) begin
				div_q <= bus_req.wdata; // [RL7]
			end
			if (bus_req.addr == cric_pkg::ADDR_FUNC_SET) begin
				function_setting_q <= bus_req.wdata & 8'h30; // [RL8]
			end
		end
	end

	// wakeup clock: rc ticks prescaled, then divided by 2 x (n + 1)
	// a new divider value takes effect at the next base tick
	// the tick feeds the interrupt status and the wake_tick enable, it clocks nothing
	// prescaler and divider run freely; software cannot set the phase
	logic [15:0] pre_cnt_q;
	logic [8:0] wdiv_cnt_q;
	logic wake_q, wake_tick_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pre_cnt_q <= 16'h0000;
			wdiv_cnt_q <= 9'h000;
			wake_q <= 1'b0;
			wake_tick_q <= 1'b0;
		end else begin
			wake_tick_q <= 1'b0;
			if (rc_tick_q) begin
				if (pre_cnt_q == 16'(WAKE_PRE - 1)) begin
					pre_cnt_q <= 16'h0000;
					// half period is n + 1 base ticks
					if (wdiv_cnt_q >= {1'b0, div_q}) begin
						wdiv_cnt_q <= 9'h000; // [RL7]
						wake_q <= !wake_q;
						wake_tick_q <= !wake_q; // [RL6]
					end else begin
						wdiv_cnt_q <= wdiv_cnt_q + 9'h001;
					end
				end else begin
					pre_cnt_q <= pre_cnt_q + 16'h0001;
				end
			end
		end
	end

	// interrupt status: sticky events, write one to clear, set wins
	// delayed copies turn levels into one-cycle events
	logic [7:0] ev;
	logic master_clear_pin_hit_d1_q, idle_d1_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			master_clear_pin_hit_d1_q <= 1'b0;
			idle_d1_q <= 1'b0;
		end else begin
			master_clear_pin_hit_d1_q <= master_clear_pin_hit_q;
			idle_d1_q <= processor_control_q[cric_pkg::IDLE_BIT];
		end
	end
	// event vector, one bit per status position
	always_comb begin
		ev = 8'h00;
		ev[cric_pkg::EV_WAKE] = wake_tick_q;
		ev[cric_pkg::EV_WDOG] = watchdog_overflow;
		ev[cric_pkg::EV_MASTER_CLEAR_PIN] = master_clear_pin_hit_q & !master_clear_pin_hit_d1_q;
		ev[cric_pkg::EV_IDLE_EXIT] = idle_d1_q & !processor_control_q[cric_pkg::IDLE_BIT];
	end
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ist_q <= 8'h00;
			imask_q <= 8'h00;
		end else begin
			// set wins over a clear in the same cycle so no event is lost
			// a write of zero leaves a bit as it is
			if (wr_hit(bus_req, cric_pkg::ADDR_IRQ_STAT)) begin
				ist_q <= (ist_q & ~bus_req.wdata) | ev;
			end else begin
				ist_q <= ist_q | ev;
			end
			if (wr_hit(bus_req, cric_pkg::ADDR_IRQ_MASK)) begin
				imask_q <= bus_req.wdata & 8'h0f;
			end
		end
	end

	// read data, one cycle after the read strobe, zero otherwise
	// a read has no side effect, so a repeated read is always safe
	// the divider is write only and reads as zero
	logic [7:0] rdata_d;
	always_comb begin
		rdata_d = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				cric_pkg::ADDR_PROC_CTRL: rdata_d = processor_control_q |
					{3'b000, pof_q, 4'h0};
				cric_pkg::ADDR_CLK_CTRL0: rdata_d = ck0_q;
				cric_pkg::ADDR_FUNC_SET: rdata_d = function_setting_q;
				cric_pkg::ADDR_IRQ_STAT: rdata_d = ist_q;
				cric_pkg::ADDR_IRQ_MASK: rdata_d = imask_q;
				cric_pkg::ADDR_SYS_STAT: rdata_d = {5'h00, wake_q,
					in_reset_q, master_clear_pin_hit_q};
				default: rdata_d = 8'h00; // divider is write only
			endcase
		end
	end

	// output clock select: the chosen source is retimed through one flop
	// the pin follows its source two clocks late; a source faster than
	// half of clk_sys would alias, a known limit of sampling it here
	logic hs_half_q, hs_prev_q, oc_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			hs_half_q <= 1'b0;
			hs_prev_q <= 1'b0;
			oc_q <= 1'b0;
		end else begin
			// halve the oscillator: toggle on each of its rising edges
			hs_prev_q <= hs_clk_in;
			if (hs_clk_in && !hs_prev_q) begin
				hs_half_q <= !hs_half_q; // [RL8]
			end
			unique case (cric_pkg::cric_oc_e'(function_setting_q[cric_pkg::OUTPUT_CLOCK_SELECT_LO +: 2]))
				cric_pkg::CRIC_OC_OFF: oc_q <= 1'b0; // [RL8]
				cric_pkg::CRIC_OC_USB: oc_q <= usb_clk_in;
				cric_pkg::CRIC_OC_HS: oc_q <= hs_clk_in;
				cric_pkg::CRIC_OC_HS2: oc_q <= hs_half_q;
			endcase
		end
	end

	// registered outputs
	// every output leaves through a flop so the pins never glitch while
	// the selection logic settles
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			bus_rdata <= 8'h00;
			clock_output_pin <= 1'b0;
			sys_reset_n <= 1'b0;
			cpu_run <= 1'b0;
			fetch_addr <= cric_pkg::FETCH_ADDR;
			clk_en <= '0;
			irq <= 1'b0;
		end else begin
			bus_rdata <= rdata_d;
			clock_output_pin <= oc_q;
			sys_reset_n <= !in_reset_q; // [RL11]
			// only the processor clock stops in idle
			cpu_run <= !in_reset_q && !processor_control_q[cric_pkg::IDLE_BIT]; // [RL16]
			// restart address is fixed; every reset restarts at zero
			fetch_addr <= cric_pkg::FETCH_ADDR; // [RL11] [RL18]
			clk_en.cpu_clk_en <= !processor_control_q[cric_pkg::IDLE_BIT];
			clk_en.pll_en <= ck0_q[cric_pkg::PLL_ENABLE_BIT_BIT]; // [RL3] [RL4]
			// rc runs for watchdog, reset state or oscillator resume
			clk_en.rc_osc_en <= watchdog_enabled | in_reset_q |
				osc_resume; // [RL1] [RL2]
			clk_en.wake_tick <= wake_tick_q; // [RL6]
			irq <= |(ist_q & imask_q);
		end
	end
endmodule : cric_top

// *** tb/cric_top_monitor.sv ***
// checker for the port behaviour of the clock, reset and idle control block
`timescale 1ns/1ps
module cric_top_monitor (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire cric_pkg::cric_req_s bus_req,
	input wire logic [7:0] bus_rdata,
	input wire logic master_clear_pin_n,
	input wire logic poweron_detect_out,
	input wire logic watchdog_overflow,
	input wire logic watchdog_enabled,
	input wire logic osc_resume,
	input wire logic port_wake_pd,
	input wire logic rt_wake_pd,
	input wire logic irq_pending,
	input wire logic usb_clk_in,
	input wire logic hs_clk_in,
	input wire logic clock_output_pin,
	input wire logic sys_reset_n,
	input wire logic cpu_run,
	input wire logic [15:0] fetch_addr,
	input wire cric_pkg::cric_clk_s clk_en,
	input wire logic irq
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// read data only in the slot after a read strobe
	property p_rdata; !$past(bus_req.rd) |-> bus_rdata == 8'h00; endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data outside its slot");
	property p_fetch; fetch_addr == 16'h0000; endproperty
	a_fetch: assert property (p_fetch)
		else $error("restart address not zero");
	// pll enable follows bit 4 of a clock control write two edges on
	property p_pll; bus_req.wr && bus_req.addr == 8'h91 && sys_reset_n
		|-> ##2 clk_en.pll_en == $past(bus_req.wdata[4], 2); endproperty
	a_pll: assert property (p_pll)
		else $error("pll enable does not follow write");
	property p_idle; bus_req.wr && bus_req.addr == 8'h87 && bus_req.wdata[0]
		&& sys_reset_n && !irq_pending |-> ##[1:3] !cpu_run; endproperty
	a_idle: assert property (p_idle)
		else $error("idle write did not stop processor");
	property p_wake; sys_reset_n && !cpu_run && irq_pending
		|-> ##[1:3] cpu_run; endproperty
	a_wake: assert property (p_wake)
		else $error("pending interrupt did not wake");
	property p_wdog; $rose(watchdog_overflow) && sys_reset_n
		|-> ##[1:12] !sys_reset_n; endproperty
	a_wdog: assert property (p_wdog)
		else $error("watchdog overflow gave no reset");
	property p_rc; watchdog_enabled || osc_resume || !sys_reset_n
		|-> ##[0:5] clk_en.rc_osc_en; endproperty
	a_rc: assert property (p_rc)
		else $error("rc oscillator not enabled");
	// a short window is checked so the bound suits any stabilisation count
	property p_stab; $rose(poweron_detect_out) |-> !sys_reset_n [*8]; endproperty
	a_stab: assert property (p_stab)
		else $error("reset released too early");
endmodule : cric_top_monitor
bind cric_top cric_top_monitor u_mon (.*);

// *** tb/cric_clk_sink.sv ***
// off-chip peripheral model that counts edges of the shared clock
`timescale 1ns/1ps
module cric_clk_sink (
	input wire logic clk_in,
	output int edges
);
	// a peripheral only reacts to rising edges of the pin
	initial edges = 0;
	// the pin is taken as already set to output by software
	always @(posedge clk_in) begin
		edges <= edges + 1;
	end
endmodule : cric_clk_sink

// *** tb/tb.sv ***
// self-checking bench for the clock, reset and idle control block
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	cric_pkg::cric_req_s bus_req = '0;
	logic [7:0] bus_rdata;
	logic master_clear_pin_n = 1'b1, poweron_detect_out = 1'b1;
	logic watchdog_overflow = 1'b0, watchdog_enabled = 1'b0;
	logic osc_resume = 1'b0, port_wake_pd = 1'b0, rt_wake_pd = 1'b0;
	logic irq_pending = 1'b0, usb_clk_in = 1'b0, hs_clk_in = 1'b0;
	logic clock_output_pin, sys_reset_n, cpu_run, irq, fell_q = 1'b0;
	logic [15:0] fetch_addr;
	cric_pkg::cric_clk_s clk_en;
	logic [15:0] exp_e [4] = '{16'h0, 16'h8, 16'h10, 16'h8}; // edges per sel
	int errors = 0, checks_done = 0, edges, n, t0, t1, t2, cyc_n = 0;
	logic [2:0] ph = 3'h0; // source clocks derived from this count
	always #10 clk_sys = ~clk_sys;
	// small counts keep every reset and wakeup period short
	cric_top #(.STAB_COUNT(4), .FILT_COUNT(2), .RC_DIV(4), .WAKE_PRE(2)) uut (.*);
	cric_clk_sink sink (.clk_in(clock_output_pin), .edges(edges));
	always @(posedge clk_sys) begin
		cyc_n++;
		ph <= ph + 3'h1;
		hs_clk_in <= ph[1];
		usb_clk_in <= ph[2];
	end
	always @(negedge sys_reset_n) fell_q = 1'b1;
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) bus_req <= '0;
	endtask : wr
	task automatic rd(input logic [7:0] a, exp, input string nm);
		@(posedge clk_sys) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys) bus_req <= '0;
		#1 chk(nm, {8'h00, bus_rdata}, {8'h00, exp});
	endtask : rd
	// bounded waits: for a reset to start, then for it to end
	task automatic rst_cycle(input string nm);
		for (int k = 0; k < 80 && fell_q !== 1'b1; k++) cyc(1);
		chk(nm, {15'h0, fell_q}, 16'h1);
		for (int k = 0; k < 400 && sys_reset_n !== 1'b1; k++) cyc(1);
		chk("release", {15'h0, sys_reset_n}, 16'h1);
	endtask : rst_cycle
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	initial begin
		#300000;
		errors++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		fell_q = 1'b1;
		rst_cycle("power up");
		rd(8'h87, 8'h10, "proc control");
		rd(8'h91, 8'h00, "clock control");
		rd(8'hd4, 8'h00, "divider");
		rd(cric_pkg::ADDR_FUNC_SET, 8'h00, "function setting");
		rd(8'h55, 8'h00, "unmapped");
		chk("fetch", fetch_addr, 16'h0000);
		wr(8'h87, 8'h00);
		rd(8'h87, 8'h00, "flag cleared");
		$display("test reset values done");
		// the watchdog and both wakeup sources must clear the pll enable but keep the flag
		for (n = 0; n < 3; n++) begin
			wr(8'h91, 8'h10);
			cyc(3);
			chk("pll on", clk_en.pll_en, 1'b1);
			fell_q = 1'b0;
			@(posedge clk_sys) {rt_wake_pd, port_wake_pd, watchdog_overflow} <= 3'(1 << n);
			@(posedge clk_sys) {rt_wake_pd, port_wake_pd, watchdog_overflow} <= 3'h0;
			rst_cycle("source reset");
			rd(8'h91, 8'h00, "pll after reset");
			rd(8'h87, 8'h00, "flag kept");
		end
		fell_q = 1'b0;
		@(posedge clk_sys) master_clear_pin_n <= 1'b0;
		cyc(3);
		@(posedge clk_sys) master_clear_pin_n <= 1'b1;
		cyc(40);
		chk("short clear", {15'h0, fell_q}, 16'h0);
		@(posedge clk_sys) master_clear_pin_n <= 1'b0;
		cyc(40);
		@(posedge clk_sys) master_clear_pin_n <= 1'b1;
		rst_cycle("long clear");
		fell_q = 1'b0;
		@(posedge clk_sys) poweron_detect_out <= 1'b0;
		cyc(20);
		@(posedge clk_sys) poweron_detect_out <= 1'b1;
		rst_cycle("power drop");
		rd(8'h87, 8'h10, "flag set");
		$display("test reset sources done");
		wr(8'h91, 8'h10);
		@(posedge clk_sys) {watchdog_enabled, osc_resume} <= 2'b11;
		wr(8'h87, 8'h11);
		cyc(4);
		chk("cpu stopped", cpu_run, 1'b0);
		chk("cpu clock gated", clk_en.cpu_clk_en, 1'b0);
		chk("pll kept", clk_en.pll_en, 1'b1);
		chk("rc on", clk_en.rc_osc_en, 1'b1);
		@(posedge clk_sys) irq_pending <= 1'b1;
		cyc(4);
		chk("cpu resumed", cpu_run, 1'b1);
		chk("cpu clock back", clk_en.cpu_clk_en, 1'b1);
		@(posedge clk_sys) {watchdog_enabled, osc_resume, irq_pending} <= 3'h0;
		rd(8'h87, 8'h10, "idle cleared");
		$display("test idle done");
		wr(cric_pkg::ADDR_IRQ_MASK, 8'h00);
		wr(8'hd4, 8'h00);
		cyc(40);
		chk("masked irq", irq, 1'b0);
		wr(cric_pkg::ADDR_IRQ_MASK, 8'h01);
		cyc(3);
		chk("irq raised", irq, 1'b1);
		// period is two times n plus one base half periods
		for (n = 0; n < 3; n++) begin
			wr(8'hd4, 8'(n));
			for (int k = 0; k < 3; k++) begin
				for (int j = 0; j < 200 && clk_en.wake_tick !== 1'b1; j++) cyc(1);
				{t0, t1, t2} = {t1, t2, cyc_n};
				cyc(1);
			end
			chk("wake period", 16'(t2 - t1), 16'(16 * (n + 1)));
		end
		wr(8'hd4, 8'hff);
		wr(cric_pkg::ADDR_IRQ_STAT, 8'h0f);
		cyc(3);
		chk("irq cleared", irq, 1'b0);
		rd(cric_pkg::ADDR_IRQ_STAT, 8'h00, "status cleared");
		rd(cric_pkg::ADDR_IRQ_MASK, 8'h01, "mask kept");
		$display("test wakeup done");
		for (n = 0; n < 4; n++) begin
			wr(cric_pkg::ADDR_FUNC_SET, 8'(n << 4));
			cyc(8);
			t0 = edges;
			cyc(64);
			chk("clock edges", 16'(edges - t0), exp_e[n]);
		end
		$display("test clock output done");
		close_out();
	end
endmodule : tb
